// *** verilog/dcs_defines.vh ***
// constants of the dual card select control block
// assumes a 20 MHz system clock and a 32-bit classic wishbone register bus
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define DCS_CLK_HZ            20000000
`define DCS_DEBOUNCE_MS       8
// 8 ms at 20 MHz, sized to the 18-bit debounce counter
`define DCS_DEBOUNCE_CYC      18'h27100

// ****************************************
// register map (byte addresses)
// ****************************************
`define DCS_ADDR_CTRL         4'h0
`define DCS_ADDR_STATUS       4'h4

// control register fields and reset values
`define DCS_CTRL_DATA_EN      0
`define DCS_CTRL_CLOCK_EN     1
`define DCS_CTRL_RESET        2'h3

// synchroniser reset: idle pin levels, activation request and data lines high
`define DCS_SYNC_RESET        13'h0813

// status register fields
`define DCS_ST_PRES_FIRST     0
`define DCS_ST_PRES_SECOND    1
`define DCS_ST_ACT_FIRST      2
`define DCS_ST_ACT_SECOND     3
`define DCS_ST_SELECT         4
`define DCS_ST_STOP           5
`define DCS_ST_LOW_VOLT       6

// ****************************************
// divider select codes {first, second}
// ****************************************
`define DCS_DIV_8             2'h0
`define DCS_DIV_4             2'h1
`define DCS_DIV_1             2'h2
`define DCS_DIV_2             2'h3

// ****************************************
// card supply codes
// ****************************************
`define DCS_VCC_OFF           2'h0
`define DCS_VCC_1V8           2'h1
`define DCS_VCC_3V            2'h2
`define DCS_VCC_5V            2'h3

`endif

// *** verilog/dcs_dual_card_select.v ***
// select and control logic of a dual smart-card front end
// assumes all host and card pins are asynchronous to clk_i and are synchronised here;
// open-drain data lines are resolved outside from the output enables
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`include "dcs_defines.vh"

module dcs_dual_card_select #(
    parameter [17:0] DEBOUNCE_CYCLES = `DCS_DEBOUNCE_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // host control pins
    input  wire        interface_select_i,
    input  wire        activation_request_n_i,
    input  wire        host_card_reset_request_i,
    input  wire        card_voltage_high_low_select_i,
    input  wire        low_voltage_card_mode_i,
    input  wire        divider_select_first_i,
    input  wire        divider_select_second_i,
    input  wire        reference_clock_input_i,
    input  wire        host_data_line_i,
    output wire        host_data_line_o,
    output wire        host_data_line_oe_n_o,
    output wire        selected_presence_irq_n_o,
    output wire        unselected_side_presence_out_n_o,
    output reg         stop_mode_o,
    // card side
    input  wire        card_presence_first_i,
    input  wire        card_presence_second_i,
    input  wire        card_data_line_first_i,
    output wire        card_data_line_first_o,
    output wire        card_data_line_first_oe_n_o,
    input  wire        card_data_line_second_i,
    output wire        card_data_line_second_o,
    output wire        card_data_line_second_oe_n_o,
    output wire        card_clock_out_first_o,
    output wire        card_clock_out_second_o,
    output wire        card_reset_out_first_o,
    output wire        card_reset_out_second_o,
    output wire [1:0]  card_supply_first_o,
    output wire [1:0]  card_supply_second_o
);

    // ****************************************
    // supply code of an interface at activation
    // ****************************************
    function [1:0] dcs_vcc_code;
        input low_volt;
        input high_sel;
        begin
            if (low_volt) begin
                dcs_vcc_code = `DCS_VCC_1V8;
            end else if (high_sel) begin
                dcs_vcc_code = `DCS_VCC_5V;
            end else begin
                dcs_vcc_code = `DCS_VCC_3V;
            end
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam SYNC_W = 13;

    wire [SYNC_W-1:0] pins_raw;
    reg  [SYNC_W-1:0] sync1_r;
    reg  [SYNC_W-1:0] sync2_r;

    assign pins_raw = {interface_select_i, activation_request_n_i, host_card_reset_request_i,
                       card_voltage_high_low_select_i, low_voltage_card_mode_i,
                       divider_select_first_i, divider_select_second_i, reference_clock_input_i,
                       host_data_line_i, card_presence_second_i, card_presence_first_i,
                       card_data_line_second_i, card_data_line_first_i};

    always @(posedge clk_i) begin
        if (rst_i) begin
            // idle levels, so that no false reference edge or stop request follows reset
            sync1_r <= `DCS_SYNC_RESET;
            sync2_r <= `DCS_SYNC_RESET;
        end else if (ce_i) begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    wire       sel_s    = sync2_r[12];
    wire       act_n_s  = sync2_r[11];
    wire       rstreq_s = sync2_r[10];
    wire       vhigh_s  = sync2_r[9];
    wire       lowv_s   = sync2_r[8];
    wire [1:0] div_s    = sync2_r[7:6];
    wire       ref_s    = sync2_r[5];
    wire       host_s   = sync2_r[4];
    wire [1:0] pres_s   = sync2_r[3:2];
    wire [1:0] card_s   = sync2_r[1:0];

    // ****************************************
    // registers seen by software
    // ****************************************
    reg  [1:0] ctrl_r;
    wire       stop_nxt;
    wire       wb_req;
    reg  [1:0] active_r;
    reg  [1:0] pres_deb_r;

    assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // all three high select the stop state; activation request high also deactivates
    assign stop_nxt = act_n_s & vhigh_s & lowv_s;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= `DCS_CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && wb_we_i && wb_adr_i == `DCS_ADDR_CTRL && wb_sel_i[0]) begin
                ctrl_r <= wb_dat_i[1:0];
            end
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `DCS_ADDR_CTRL: begin
                        wb_dat_o <= {30'h00000000, ctrl_r};
                    end
                    `DCS_ADDR_STATUS: begin
                        wb_dat_o <= {25'h0000000, lowv_s, stop_mode_o, sel_s, active_r, pres_deb_r};
                    end
                    default: begin
                        wb_dat_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            stop_mode_o <= 1'b0;
        end else if (ce_i) begin
            stop_mode_o <= stop_nxt;
        end
    end

    // ****************************************
    // card clock divider
    // ****************************************
    // the reference is oversampled by clk_i, so it must run well below 10 MHz
    reg       ref_d_r;
    reg [2:0] div_cnt_r;
    reg       div_clk_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ref_d_r   <= 1'b0;
            div_cnt_r <= 3'h0;
            div_clk_r <= 1'b0;
        end else if (ce_i) begin
            ref_d_r <= ref_s;
            if (ref_s && !ref_d_r) begin
                div_cnt_r <= div_cnt_r + 3'h1;
            end
            case (div_s)
                `DCS_DIV_8: begin
                    div_clk_r <= div_cnt_r[2];
                end
                `DCS_DIV_4: begin
                    div_clk_r <= div_cnt_r[1];
                end
                `DCS_DIV_2: begin
                    div_clk_r <= div_cnt_r[0];
                end
                default: begin
                    div_clk_r <= ref_s;
                end
            endcase
        end
    end

    // ****************************************
    // per-interface logic, index 0 is A, 1 is B
    // ****************************************
    reg  [17:0] deb_cnt_r [0:1];
    reg  [1:0]  card_rst_r;
    reg  [1:0]  card_clk_r;
    reg  [1:0]  vcc_r [0:1];
    reg  [1:0]  card_drv_r;
    reg         host_drv_r;
    reg  [2:0]  drv_d1_r;
    reg  [2:0]  drv_d2_r;
    wire [1:0]  is_sel;
    wire [1:0]  route;

    assign is_sel = {sel_s, ~sel_s};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_if
            assign route[gi] = is_sel[gi] & active_r[gi] & ctrl_r[`DCS_CTRL_DATA_EN];

            always @(posedge clk_i) begin
                if (rst_i) begin
                    deb_cnt_r[gi]  <= 18'h00000;
                    pres_deb_r[gi] <= 1'b0;
                end else if (ce_i) begin
                    if (!pres_s[gi]) begin
                        deb_cnt_r[gi]  <= 18'h00000;
                        pres_deb_r[gi] <= 1'b0;
                    end else if (deb_cnt_r[gi] == DEBOUNCE_CYCLES - 18'h00001) begin
                        pres_deb_r[gi] <= 1'b1;
                    end else begin
                        deb_cnt_r[gi] <= deb_cnt_r[gi] + 18'h00001;
                    end
                end
            end

            // an unselected interface keeps its state, so both cards may stay powered
            always @(posedge clk_i) begin
                if (rst_i) begin
                    active_r[gi]   <= 1'b0;
                    vcc_r[gi]      <= `DCS_VCC_OFF;
                    card_rst_r[gi] <= 1'b0;
                    card_clk_r[gi] <= 1'b0;
                    card_drv_r[gi] <= 1'b0;
                end else if (ce_i) begin
                    if (is_sel[gi] && act_n_s) begin
                        active_r[gi] <= 1'b0;
                        vcc_r[gi]    <= `DCS_VCC_OFF;
                    end else if (is_sel[gi] && !active_r[gi]) begin
                        active_r[gi] <= 1'b1;
                        vcc_r[gi]    <= dcs_vcc_code(lowv_s, vhigh_s);
                    end
                    if (!active_r[gi]) begin
                        card_rst_r[gi] <= 1'b0;
                    end else if (is_sel[gi]) begin
                        card_rst_r[gi] <= rstreq_s;
                    end
                    card_clk_r[gi] <= active_r[gi] & ctrl_r[`DCS_CTRL_CLOCK_EN] & ~stop_mode_o & div_clk_r;
                    // whichever side pulls low first owns the line, avoiding a latch-up loop
                    card_drv_r[gi] <= route[gi] & ~host_s & ~host_drv_r & ~drv_d2_r[2];
                end
            end
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            host_drv_r <= 1'b0;
        end else if (ce_i) begin
            host_drv_r <= route[sel_s] & ~card_s[sel_s] & ~card_drv_r[sel_s] & ~drv_d2_r[sel_s];
        end
    end

    // own drive delayed to line up with the synchronisers: a line still low from
    // our own release must not be taken for the far side pulling it, or the two echo
    always @(posedge clk_i) begin
        if (rst_i) begin
            drv_d1_r <= 3'h0;
            drv_d2_r <= 3'h0;
        end else if (ce_i) begin
            drv_d1_r <= {host_drv_r, card_drv_r};
            drv_d2_r <= drv_d1_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign host_data_line_o             = 1'b0;
    assign host_data_line_oe_n_o        = ~host_drv_r;
    assign card_data_line_first_o       = 1'b0;
    assign card_data_line_first_oe_n_o  = ~card_drv_r[0];
    assign card_data_line_second_o      = 1'b0;
    assign card_data_line_second_oe_n_o = ~card_drv_r[1];
    assign card_clock_out_first_o       = card_clk_r[0];
    assign card_clock_out_second_o      = card_clk_r[1];
    assign card_reset_out_first_o       = card_rst_r[0];
    assign card_reset_out_second_o      = card_rst_r[1];
    assign card_supply_first_o          = vcc_r[0];
    assign card_supply_second_o         = vcc_r[1];

    assign selected_presence_irq_n_o        = ~pres_deb_r[sel_s];
    assign unselected_side_presence_out_n_o = ~pres_deb_r[~sel_s];

endmodule

// *** verification/dcs_host_model.sv ***
// host side partner: makes the reference clock, drives the control pins, resolves the host data line
// assumes the bench hands it pin levels at rising edges of clk_i
`timescale 1ns/1ns
module dcs_host_model (
    input  logic       clk_i,
    input  logic [5:0] pins_i,
    input  logic       block_oe_n_i,
    output logic       ref_clk_o = 1'h0,
    output logic       data_line_o,
    output logic [4:0] ctl_o = 5'h02
);
    logic [1:0] div_r = 2'h0;
    // ****************************************
    // pins and clock
    // ****************************************
    // 2.5 MHz keeps the oversampled reference clean in the block
    always_ff @(posedge clk_i) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) begin
            ref_clk_o <= ~ref_clk_o;
        end
        ctl_o <= pins_i[4:0];
    end
    // pull-up: the line is high unless a party pulls it low
    assign data_line_o = block_oe_n_i & ~pins_i[5];
endmodule

// *** verification/dcs_properties.sv ***
// concurrent checks of the dual card select block, bound to its top module
// assumes ce_i goes low only while no watched condition is building up
`timescale 1ns/1ns
`include "dcs_defines.vh"
module dcs_properties #(
    parameter [17:0] DEBOUNCE_CYCLES = 18'h14
) (
    input logic       clk_i,
    input logic       rst_i,
    input logic       interface_select_i,
    input logic       activation_request_n_i,
    input logic       host_card_reset_request_i,
    input logic       card_voltage_high_low_select_i,
    input logic       low_voltage_card_mode_i,
    input logic       card_presence_first_i,
    input logic       card_presence_second_i,
    input logic       selected_presence_irq_n_o,
    input logic       unselected_side_presence_out_n_o,
    input logic       stop_mode_o,
    input logic       card_data_line_first_oe_n_o,
    input logic       card_data_line_second_oe_n_o,
    input logic       card_reset_out_first_o,
    input logic [1:0] card_supply_first_o
);
    logic [17:0] pres_cnt_r;
    logic [2:0]  sel_lo_r;
    // ****************************************
    // helper counters
    // ****************************************
    always_ff @(posedge clk_i) begin
        pres_cnt_r <= (rst_i || !card_presence_first_i) ? 18'h0 : pres_cnt_r + {17'h0, ~&pres_cnt_r};
        sel_lo_r   <= (rst_i || interface_select_i) ? 3'h0 : sel_lo_r + {2'h0, ~&sel_lo_r};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a margin of a few cycles covers the pin synchronisers
    a_irq_after_debounce: assert property (pres_cnt_r >= DEBOUNCE_CYCLES + 18'h5 && sel_lo_r >= 3'h4
        |-> !selected_presence_irq_n_o) else $error("presence flag missing after debounce");
    a_no_early_irq: assert property (pres_cnt_r >= 18'h6 && pres_cnt_r < DEBOUNCE_CYCLES && sel_lo_r >= 3'h4
        |-> selected_presence_irq_n_o) else $error("presence flag before debounce");
    a_unsel_follows: assert property ((!interface_select_i && !card_presence_second_i)[*5]
        |-> unselected_side_presence_out_n_o) else $error("unselected flag without presence");
    a_data_first_idle: assert property (interface_select_i[*5] |-> card_data_line_first_oe_n_o)
        else $error("first data line driven while unselected");
    a_data_second_idle: assert property (!interface_select_i[*5] |-> card_data_line_second_oe_n_o)
        else $error("second data line driven while unselected");
    a_reset_passes: assert property ((!interface_select_i && !activation_request_n_i
        && host_card_reset_request_i)[*6] |-> card_reset_out_first_o) else $error("card reset not passed");
    a_stop_entry: assert property ((activation_request_n_i && card_voltage_high_low_select_i
        && low_voltage_card_mode_i)[*4] |-> stop_mode_o) else $error("stop state not entered");
    a_supply_code: assert property ((card_supply_first_o != 2'h0 && $past(card_supply_first_o) == 2'h0)
        |-> card_supply_first_o == (low_voltage_card_mode_i ? `DCS_VCC_1V8
        : card_voltage_high_low_select_i ? `DCS_VCC_5V : `DCS_VCC_3V)) else $error("wrong supply code");
    c_irq: cover property (!selected_presence_irq_n_o);
    c_stop: cover property (stop_mode_o);
    c_reset: cover property (card_reset_out_first_o);
endmodule
bind dcs_dual_card_select dcs_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (.*);

// *** verification/tb_dcs_dual_card_select.sv ***
// self-checking bench of the dual card select block
// assumes the host model drives the control pins and the card data lines have pull-ups
`timescale 1ns/1ns
`include "dcs_defines.vh"
module tb_dcs_dual_card_select;
    logic        clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        divider_select_first_i = 1'h0, divider_select_second_i = 1'h0;
    logic        card_presence_first_i = 1'h0, card_presence_second_i = 1'h0;
    logic [5:0]  pins = 6'h02;
    logic [3:0]  lanes = 4'hF;
    logic [1:0]  card_pull = 2'h0;
    logic [4:0]  ctl;
    logic        interface_select_i, activation_request_n_i, host_card_reset_request_i, reference_clock_input_i;
    logic        card_voltage_high_low_select_i, low_voltage_card_mode_i, host_data_line_i, host_data_line_o;
    logic        wb_ack_o, host_data_line_oe_n_o, selected_presence_irq_n_o, unselected_side_presence_out_n_o;
    logic        stop_mode_o, card_data_line_first_i, card_data_line_first_o, card_data_line_first_oe_n_o;
    logic        card_data_line_second_i, card_data_line_second_o, card_data_line_second_oe_n_o;
    logic        card_clock_out_first_o, card_clock_out_second_o, card_reset_out_first_o, card_reset_out_second_o;
    logic [1:0]  card_supply_first_o, card_supply_second_o;
    int          num_errors = 0, comparisons = 0, cycles = 0;
    assign {low_voltage_card_mode_i, card_voltage_high_low_select_i, host_card_reset_request_i,
            activation_request_n_i, interface_select_i} = ctl;
    // each line is the pull-up against the block's drive and the card's, set by card_pull
    assign card_data_line_first_i = card_data_line_first_oe_n_o & ~card_pull[0];
    assign card_data_line_second_i = card_data_line_second_oe_n_o & ~card_pull[1];
    dcs_dual_card_select #(.DEBOUNCE_CYCLES(18'h14)) DUT (.*);
    dcs_host_model u_host (.clk_i(clk_i), .pins_i(pins), .block_oe_n_i(host_data_line_oe_n_o),
        .ref_clk_o(reference_clock_input_i), .data_line_o(host_data_line_i), .ctl_o(ctl));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= lanes;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        r = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic summarize;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        wb(1'h0, `DCS_ADDR_CTRL, 32'h0, q);
        check(q, {30'h0, `DCS_CTRL_RESET});
        wb(1'h1, `DCS_ADDR_CTRL, 32'hFFFFFFFE, q);
        wb(1'h0, `DCS_ADDR_CTRL, 32'h0, q);
        check(q, 32'h2);
        wb(1'h1, 4'h8, 32'hFFFFFFFF, q);
        wb(1'h0, 4'h8, 32'h0, q);
        check(q, 32'h0);
        wb(1'h1, `DCS_ADDR_CTRL, 32'h3, q);
        lanes = 4'hE;
        wb(1'h1, `DCS_ADDR_CTRL, 32'h0, q);
        lanes = 4'hF;
        wb(1'h0, `DCS_ADDR_CTRL, 32'h0, q);
        check(q, 32'h3);
    endtask
    task automatic t_presence;
        card_presence_first_i <= 1'h1;
        wait_cyc(10);
        card_presence_first_i <= 1'h0;
        wait_cyc(2);
        card_presence_first_i <= 1'h1;
        wait_cyc(14);
        check(selected_presence_irq_n_o, 1'h1);
        wait_cyc(12);
        check(selected_presence_irq_n_o, 1'h0);
        card_presence_second_i <= 1'h1;
        wait_cyc(28);
        check(unselected_side_presence_out_n_o, 1'h0);
        pins[0] <= 1'h1;
        wait_cyc(6);
        check(selected_presence_irq_n_o, 1'h0);
        card_presence_first_i <= 1'h0;
        wait_cyc(6);
        check(unselected_side_presence_out_n_o, 1'h1);
        pins[0] <= 1'h0;
        wait_cyc(6);
        check(selected_presence_irq_n_o, 1'h1);
    endtask
    task automatic t_supply(input logic volt, input logic low, input logic [1:0] code);
        pins <= {1'h0, low, volt, 1'h0, 1'h1, 1'h0};
        wait_cyc(6);
        pins[1] <= 1'h0;
        wait_cyc(8);
        check(card_supply_first_o, code);
        wb(1'h0, `DCS_ADDR_STATUS, 32'h0, q);
        check(q, {25'h0, low, 6'h06});
    endtask
    task automatic t_reset_data;
        pins[2] <= 1'h1;
        wait_cyc(6);
        check(card_reset_out_first_o, 1'h1);
        pins[5] <= 1'h1;
        wait_cyc(6);
        check({card_data_line_first_oe_n_o, card_data_line_second_oe_n_o}, 2'h1);
        pins[5] <= 1'h0;
        pins[0] <= 1'h1;
        wait_cyc(8);
        check(card_reset_out_second_o, 1'h1);
        check(card_supply_second_o, `DCS_VCC_1V8);
        pins[2] <= 1'h0;
        pins[5] <= 1'h1;
        wait_cyc(6);
        check(card_reset_out_first_o, 1'h1);
        check(card_reset_out_second_o, 1'h0);
        check({card_data_line_first_oe_n_o, card_data_line_second_oe_n_o}, 2'h2);
        pins[5] <= 1'h0;
        pins[0] <= 1'h0;
        wait_cyc(6);
        card_pull[0] <= 1'h1;
        wait_cyc(6);
        check(host_data_line_oe_n_o, 1'h0);
        check({card_data_line_first_oe_n_o, card_data_line_second_oe_n_o}, 2'h3);
        card_pull[0] <= 1'h0;
        wait_cyc(6);
        check({host_data_line_oe_n_o, card_data_line_first_oe_n_o, card_data_line_second_oe_n_o}, 3'h7);
        check({host_data_line_o, card_data_line_first_o, card_data_line_second_o}, 3'h0);
    endtask
    task automatic t_freeze;
        ce_i <= 1'h0;
        pins[1] <= 1'h1;
        wait_cyc(8);
        check(card_supply_first_o, `DCS_VCC_1V8);
        ce_i <= 1'h1;
        wait_cyc(6);
        check(card_supply_first_o, `DCS_VCC_OFF);
    endtask
    task automatic t_dividers;
        longint t0;
        for (int i = 0; i < 4; i++) begin
            {divider_select_first_i, divider_select_second_i} <= i[1:0];
            wait_cyc(100);
            @(posedge card_clock_out_first_o);
            t0 = $time;
            @(posedge card_clock_out_first_o);
            check(32'(($time - t0) / 50), (i == 0) ? 64 : (i == 1) ? 32 : (i == 3) ? 16 : 8);
        end
    endtask
    task automatic t_stop;
        pins <= 6'h1A;
        wait_cyc(6);
        check(stop_mode_o, 1'h1);
        check({card_clock_out_first_o, card_clock_out_second_o}, 2'h0);
        pins[3] <= 1'h0;
        wait_cyc(6);
        check(stop_mode_o, 1'h0);
    endtask
    // ****************************************
    // clock, run and watchdog
    // ****************************************
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        wait_cyc(5);
        rst_i <= 1'h0;
        t_regs();
        t_presence();
        t_supply(1'h1, 1'h0, `DCS_VCC_5V);
        t_supply(1'h0, 1'h0, `DCS_VCC_3V);
        t_supply(1'h0, 1'h1, `DCS_VCC_1V8);
        t_reset_data();
        t_dividers();
        t_freeze();
        t_stop();
        summarize();
    end
endmodule
